// ===== logic/unb_defines.vh
// Constants for the nine-bit multiprocessor serial port
`ifndef UNB_DEFINES_VH
`define UNB_DEFINES_VH
`define UNB_CTRL_ADDR    8'h98
`define UNB_DATA_ADDR    8'h99
`define UNB_CTRL_RESET   8'h40
`define UNB_DATA_RESET   8'h00
`define UNB_BIT_MODE     7
`define UNB_BIT_UNUSED   6
`define UNB_BIT_FILTER   5
`define UNB_BIT_RXEN     4
`define UNB_BIT_TB9      3
`define UNB_BIT_RB9      2
`define UNB_BIT_TIF      1
`define UNB_BIT_RIF      0
`define UNB_RESP_OKAY    2'b00
`define UNB_RESP_SLVERR  2'b10
`endif

// ===== logic/unb_rx.v
// Receive sampler of the serial port
`timescale 1ns/1ps
`include "unb_defines.vh"
module unb_rx (
  input  wire       aclk,      // Clock
  input  wire       aresetn,   // Sync reset, low
  input  wire       ovf_tick,  // Timer overflow
  input  wire       rxd,       // Serial in
  input  wire       enable,    // Receive enabled
  input  wire       nine_bit,  // Frame mode
  output reg  [7:0] rx_data,   // Captured byte
  output reg        rx_ninth,  // Ninth or stop bit
  output reg        rx_stop,   // Stop level
  output reg        frame_end  // Stop sampled pulse
);
  reg       busy_r;
  reg [1:0] phase_r;
  reg [3:0] cnt_r;
  reg       rxd_d_r;
  wire [3:0] stop_idx = nine_bit ? 4'hA : 4'h9;
  // One bit is two overflows; sample on alternate overflows, starting with the first
  wire samp = ovf_tick & (phase_r == 2'b00);
  always @(posedge aclk) begin
    frame_end <= 1'b0;
    if (!aresetn) begin
      busy_r <= 1'b0;
      phase_r <= 2'b00;
      cnt_r <= 4'h0;
      rxd_d_r <= 1'b1;
      rx_data <= 8'h00;
      rx_ninth <= 1'b0;
      rx_stop <= 1'b0;
    end else begin
      rxd_d_r <= rxd;
      if (!busy_r) begin
        if (enable && rxd_d_r && !rxd) begin
          // Phase cleared on start edge; first sample at the next overflow, at most half a bit on
          busy_r <= 1'b1;
          phase_r <= 2'b00;
          cnt_r <= 4'h0;
        end
      end else if (ovf_tick) begin
        phase_r <= {1'b0, ~phase_r[0]};
        if (samp) begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h0 && rxd)
            busy_r <= 1'b0;
          else if (cnt_r >= 4'h1 && cnt_r <= 4'h8)
            rx_data <= {rxd, rx_data[7:1]};
          else if (cnt_r == 4'h9 && nine_bit)
            rx_ninth <= rxd;
          if (cnt_r == stop_idx) begin
            rx_stop <= rxd;
            if (!nine_bit)
              rx_ninth <= rxd;
            frame_end <= 1'b1;
            busy_r <= 1'b0;
          end
        end
      end
    end
  end
endmodule // unb_rx

// ===== logic/unb_tx.v
// Transmit shifter of the serial port
`timescale 1ns/1ps
`include "unb_defines.vh"
module unb_tx (
  input  wire       aclk,       // Clock
  input  wire       aresetn,    // Sync reset, low
  input  wire       ovf_tick,   // Timer overflow
  input  wire       start,      // Load and send
  input  wire [7:0] data,       // Byte to send
  input  wire       nine_bit,   // Frame mode
  input  wire       tb9,        // Ninth bit value
  output reg        txd,        // Serial out
  output reg        done_pulse, // Data part ended
  output wire       busy        // Frame in progress
);
  reg [9:0] shift_r;
  reg [3:0] cnt_r;
  reg       half_r;
  reg       busy_r;
  wire      bit_tick = ovf_tick & half_r;
  wire [3:0] last_data = nine_bit ? 4'h9 : 4'h8;
  assign busy = busy_r;
  always @(posedge aclk) begin
    done_pulse <= 1'b0;
    if (!aresetn) begin
      shift_r <= 10'h3FF;
      cnt_r   <= 4'h0;
      half_r  <= 1'b0;
      busy_r  <= 1'b0;
      txd     <= 1'b1;
    end else if (start) begin
      // Start bit low, then LSB first; ninth slot filled by mode
      shift_r <= {1'b1, nine_bit ? tb9 : 1'b1, data};
      cnt_r   <= 4'h0;
      half_r  <= 1'b0;
      busy_r  <= 1'b1;
      txd     <= 1'b0;
    end else if (busy_r) begin
      if (ovf_tick)
        half_r <= ~half_r;
      if (bit_tick) begin
        cnt_r   <= cnt_r + 4'h1;
        txd     <= shift_r[0];
        shift_r <= {1'b1, shift_r[9:1]};
        if (cnt_r == last_data)
          done_pulse <= 1'b1;
        if (cnt_r == last_data + 4'h1)
          busy_r <= 1'b0;
      end
    end else begin
      txd <= 1'b1;
    end
  end
endmodule // unb_tx

// ===== logic/unb_uart.v
// Serial port top: AXI4-Lite registers, transmitter and receiver
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "unb_defines.vh"
module unb_uart #(
  parameter [7:0] CTRL_ADDR = `UNB_CTRL_ADDR, // Control register index
  parameter [7:0] DATA_ADDR = `UNB_DATA_ADDR  // Data register index
) (
  input  wire        aclk,          // Clock
  input  wire        aresetn,       // Sync reset, low
  input  wire [11:0] s_axi_awaddr,  // Write address
  input  wire        s_axi_awvalid, // Write address valid
  output wire        s_axi_awready, // Write address ready
  input  wire [31:0] s_axi_wdata,   // Write data
  input  wire [3:0]  s_axi_wstrb,   // Write strobes
  input  wire        s_axi_wvalid,  // Write data valid
  output wire        s_axi_wready,  // Write data ready
  output reg  [1:0]  s_axi_bresp,   // Write response
  output reg         s_axi_bvalid,  // Write response valid
  input  wire        s_axi_bready,  // Write response ready
  input  wire [11:0] s_axi_araddr,  // Read address
  input  wire        s_axi_arvalid, // Read address valid
  output wire        s_axi_arready, // Read address ready
  output reg  [31:0] s_axi_rdata,   // Read data
  output reg  [1:0]  s_axi_rresp,   // Read response
  output reg         s_axi_rvalid,  // Read valid
  input  wire        s_axi_rready,  // Read ready
  input  wire        timer_ovf,     // Baud timer overflow
  input  wire        serial_in_pin, // Serial receive line
  output wire        serial_out_pin,// Serial transmit line
  output wire        irq            // Port interrupt
);
  reg [7:0]  ctrl_r;
  reg [7:0]  rx_latch_r;
  reg [11:0] awaddr_r;
  reg        aw_have_r;
  reg [31:0] wdata_r;
  reg        wstrb0_r;
  reg        w_have_r;
  reg        tx_start_r;
  reg [7:0]  tx_byte_r;
  wire       tx_done;
  wire [7:0] rx_data;
  wire       rx_ninth;
  wire       rx_stop;
  wire       frame_end;

  function is_reg;
    input [11:0] a;
    input [7:0]  idx;
    begin
      is_reg = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
    end
  endfunction

  wire nine_bit = ctrl_r[`UNB_BIT_MODE];
  wire filter = ctrl_r[`UNB_BIT_FILTER];

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  wire wr_ctrl = wr_fire && wstrb0_r && is_reg(awaddr_r, CTRL_ADDR);
  wire wr_data = wr_fire && wstrb0_r && is_reg(awaddr_r, DATA_ADDR);
  wire wr_ok = is_reg(awaddr_r, CTRL_ADDR) || is_reg(awaddr_r, DATA_ADDR);

  // Acceptance: flag clear and filter passes in either mode
  wire accept = frame_end && !ctrl_r[`UNB_BIT_RIF] && (!filter || (nine_bit ? rx_ninth : rx_stop));

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UNB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `UNB_RESP_OKAY : `UNB_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register; hardware sets win over software clears
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `UNB_CTRL_RESET;
      rx_latch_r <= `UNB_DATA_RESET;
      tx_start_r <= 1'b0;
      tx_byte_r <= 8'h00;
    end else begin
      tx_start_r <= wr_data;
      if (wr_data)
        tx_byte_r <= wdata_r[7:0];
      if (wr_ctrl)
        ctrl_r <= {wdata_r[7], 1'b1, wdata_r[5:0]};
      if (tx_done)
        ctrl_r[`UNB_BIT_TIF] <= 1'b1;
      if (accept) begin
        rx_latch_r <= rx_data;
        ctrl_r[`UNB_BIT_RB9] <= rx_ninth;
        ctrl_r[`UNB_BIT_RIF] <= 1'b1;
      end
      // Rejected frames leave latch, ninth bit and flag alone
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `UNB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `UNB_RESP_OKAY;
      if (is_reg(s_axi_araddr, CTRL_ADDR))
        s_axi_rdata <= {24'h000000, ctrl_r};
      else if (is_reg(s_axi_araddr, DATA_ADDR))
        s_axi_rdata <= {24'h000000, rx_latch_r};
      else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `UNB_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign irq = ctrl_r[`UNB_BIT_TIF] | ctrl_r[`UNB_BIT_RIF];

  unb_tx u_tx (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ovf_tick   (timer_ovf),
    .start      (tx_start_r),
    .data       (tx_byte_r),
    .nine_bit   (nine_bit),
    .tb9        (ctrl_r[`UNB_BIT_TB9]),
    .txd        (serial_out_pin),
    .done_pulse (tx_done),
    .busy       ()
  );

  unb_rx u_rx (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ovf_tick  (timer_ovf),
    .rxd       (serial_in_pin),
    .enable    (ctrl_r[`UNB_BIT_RXEN]),
    .nine_bit  (nine_bit),
    .rx_data   (rx_data),
    .rx_ninth  (rx_ninth),
    .rx_stop   (rx_stop),
    .frame_end (frame_end)
  );
endmodule // unb_uart

// ===== tb/unb_peer.sv
// Far serial node sending frames onto the receive line
`timescale 1ns/1ps
module unb_peer (
  input  wire        aclk, // Clock
  input  wire        tick, // Timer overflow
  input  wire        go,   // Start a frame
  input  wire [10:0] frm,  // Frame, first bit in bit 0
  input  wire [3:0]  len,  // Bits in frame
  output reg         line, // Serial line
  output reg         busy  // Frame under way
);
  reg [10:0] sh_r;
  reg [3:0]  cnt_r;
  reg        ph_r;
  initial line = 1'b1;
  initial busy = 1'b0;
  always @(posedge aclk) begin
    if (go) begin
      line  <= frm[0];
      sh_r  <= frm >> 1;
      cnt_r <= len - 4'd1;
      ph_r  <= 1'b0;
      busy  <= 1'b1;
    end else if (busy && tick) begin
      ph_r <= !ph_r;
      if (ph_r && cnt_r == 4'd0) begin
        line <= 1'b1;
        busy <= 1'b0;
      end else if (ph_r) begin
        line  <= sh_r[0];
        sh_r  <= sh_r >> 1;
        cnt_r <= cnt_r - 4'd1;
      end
    end
  end
endmodule // unb_peer

// ===== tb/unb_uart_checker.sv
// Bus and serial-line checks for the serial port
`timescale 1ns/1ps
module unb_uart_checker (
  input wire        aclk,           // Clock
  input wire        aresetn,        // Reset, low
  input wire [11:0] s_axi_araddr,   // Read addr
  input wire        s_axi_arvalid,  // Read addr valid
  input wire        s_axi_arready,  // Read addr ready
  input wire        s_axi_awready,  // Write addr ready
  input wire        s_axi_wvalid,   // Write data valid
  input wire        s_axi_wready,   // Write data ready
  input wire        s_axi_bvalid,   // Write resp valid
  input wire        s_axi_bready,   // Write resp ready
  input wire [31:0] s_axi_rdata,    // Read data
  input wire [1:0]  s_axi_rresp,    // Read resp
  input wire        s_axi_rvalid,   // Read valid
  input wire        s_axi_rready,   // Read ready
  input wire        serial_out_pin, // Tx line
  input wire        irq             // Interrupt
);
  localparam [11:0] CTL = 12'h260;
  localparam [11:0] DAT = 12'h264;
  reg [11:0] rd_a_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) rd_a_r <= s_axi_araddr;
  end
  chk_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_rvalid_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  chk_start_len: assert property ($fell(serial_out_pin) |=> !serial_out_pin [*3])
    else $error("start bit too short");
  chk_irq_read: assert property ($rose(s_axi_rvalid) && rd_a_r == CTL |-> (s_axi_rdata[1:0] != 2'b00) == $past(irq))
    else $error("irq differs from flags");
  chk_unused_bit: assert property ($rose(s_axi_rvalid) && rd_a_r == CTL |-> s_axi_rdata[6])
    else $error("unused bit not one");
  chk_bad_addr: assert property ($rose(s_axi_rvalid) && rd_a_r != CTL && rd_a_r != DAT
    |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_flag_hold: assert property ($fell(irq) && $past(aresetn)
    |-> $past(s_axi_wvalid && s_axi_wready) || $past(s_axi_wvalid && s_axi_wready, 2))
    else $error("flag cleared without write");
endmodule // unb_uart_checker
bind unb_uart unb_uart_checker u_chk (.*);

// ===== tb/unb_uart_tb_top.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
module unb_uart_tb_top;
  localparam [11:0] CTL = 12'h260;
  localparam [11:0] DAT = 12'h264;
  localparam [7:0]  TMR_RELOAD = 8'hE6;
  reg         aclk, aresetn, timer_ovf, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [11:0] s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, rdat;
  reg  [10:0] frm;
  reg  [3:0]  len;
  reg  [1:0]  rrsp, brsp;
  reg  [7:0]  tmr;
  reg  [3:0]  s_axi_wstrb;
  integer     n_errors, samples_checked, cyc;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        rx_line, peer_busy, serial_out_pin, irq;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  unb_uart uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .timer_ovf(timer_ovf), .serial_in_pin(rx_line), .serial_out_pin(serial_out_pin), .irq(irq));
  unb_peer u_peer (.aclk(aclk), .tick(timer_ovf), .go(go), .frm(frm), .len(len), .line(rx_line), .busy(peer_busy));
  always #10 aclk = ~aclk;
  // Reload timer on the system clock: overflow every 26 clocks, one bit is 52
  always @(posedge aclk) begin
    tmr <= (tmr == 8'hFF) ? TMR_RELOAD : tmr + 8'h01;
    timer_ovf <= (tmr == 8'hFF);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  task print_verdict;
    begin
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      brsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task rc(input [11:0] a, input [31:0] e);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
      chk(rdat, e);
    end
  endtask
  task txcase(input [7:0] c, input [7:0] d);
    reg [10:0] f;
    integer    i;
    begin
      wr(CTL, c);
      wr(DAT, d);
      wait (serial_out_pin === 1'b0);
      // Start bit length varies with timer phase, so sample half a bit in
      repeat (26) @(negedge aclk);
      for (i = 0; i < 11; i = i + 1) begin
        f[i] = serial_out_pin;
        repeat (52) @(negedge aclk);
      end
      chk({21'h0, f}, {21'h0, c[7] ? {1'b1, c[3], d, 1'b0} : {2'b11, d, 1'b0}});
      rc(CTL, {24'h0, c | 8'h42});
      rc(DAT, 32'h0);
      wr(CTL, c);
    end
  endtask
  task rxcase(input [7:0] c, input [7:0] d, input n9, input st, input [7:0] ec, input [7:0] ed);
    begin
      wr(CTL, c);
      frm <= c[7] ? {st, n9, d, 1'b0} : {1'b1, st, d, 1'b0};
      len <= c[7] ? 4'd11 : 4'd10;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      @(posedge aclk);
      while (peer_busy) @(posedge aclk);
      repeat (4) @(posedge aclk);
      rc(CTL, {24'h0, ec});
      rc(DAT, {24'h0, ed});
      chk({31'h0, irq}, {31'h0, ec[0] | ec[1]});
    end
  endtask
  initial begin
    {aclk, aresetn, timer_ovf, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 9'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, len} = 60'h0;
    tmr = TMR_RELOAD;
    s_axi_wstrb = 4'hF;
    frm = 11'h7FF;
    {n_errors, samples_checked, cyc} = 96'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(CTL, 32'h40);
    rc(DAT, 32'h0);
    wr(CTL, 8'hBF);
    rc(CTL, 32'hFF);
    chk({31'h0, irq}, 32'h1);
    wr(CTL, 8'h00);
    chk({30'h0, brsp}, 32'h0);
    rc(CTL, 32'h40);
    // Lane 0 strobe low: write must be dropped
    s_axi_wstrb <= 4'h0;
    wr(CTL, 8'h10);
    s_axi_wstrb <= 4'hF;
    rc(CTL, 32'h40);
    rc(12'h100, 32'h0);
    chk({30'h0, rrsp}, 32'h2);
    wr(12'h100, 8'h00);
    chk({30'h0, brsp}, 32'h2);
    txcase(8'h88, 8'hA5);
    txcase(8'h80, 8'h5A);
    txcase(8'h00, 8'h3C);
    rxcase(8'h90, 8'h96, 1'b1, 1'b0, 8'hD5, 8'h96);
    rxcase(8'hD5, 8'h11, 1'b0, 1'b1, 8'hD5, 8'h96);
    rxcase(8'hB0, 8'h22, 1'b0, 1'b1, 8'hF0, 8'h96);
    rxcase(8'hB0, 8'h33, 1'b1, 1'b1, 8'hF5, 8'h33);
    rxcase(8'h90, 8'h3A, 1'b0, 1'b1, 8'hD1, 8'h3A);
    rxcase(8'h80, 8'h44, 1'b1, 1'b1, 8'hC0, 8'h3A);
    rxcase(8'h30, 8'h55, 1'b0, 1'b0, 8'h70, 8'h3A);
    rxcase(8'h30, 8'h66, 1'b0, 1'b1, 8'h75, 8'h66);
    rxcase(8'h10, 8'h77, 1'b0, 1'b0, 8'h51, 8'h77);
    print_verdict;
  end
endmodule // unb_uart_tb_top
